// >>> shared/sarcs_pkg.sv
package sarcs_pkg;
  // ----------------------------------------------------------------
  // geometry and codes
  // ----------------------------------------------------------------
  localparam int unsigned RES_BITS = 16;
  localparam logic [15:0] CODE_POS_SAT = 16'h7fff;
  localparam logic [15:0] CODE_NEG_SAT = 16'h8000;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] TRIAL_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MAX_RATE_SPS = 250_000;
  // longest cycle count allowed per conversion, rounded down
  localparam int unsigned CYCLES_PER_SAMPLE = CLK_HZ / MAX_RATE_SPS;
  localparam int unsigned SETTLE_CYCLES = 2;
  // powered cycles of one conversion: settle, move to ground, one per bit, done
  localparam int unsigned CONV_CYCLES = SETTLE_CYCLES + RES_BITS + 2;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    SARCS_ACQ,
    SARCS_OPEN_GND,
    SARCS_TO_GND,
    SARCS_SEARCH,
    SARCS_DONE
  } sarcs_state_t;

  // switch array command; 0 = element on ground, 1 = element on reference
  typedef struct packed {
    logic pos_comparator_ground_switch;
    logic neg_comparator_ground_switch;
    logic inputs_connected;
    logic [15:0] pos_elem_ref;
    logic [15:0] neg_elem_ref;
  } sarcs_sw_t;

  typedef struct packed {
    logic [15:0] code;
    logic pos_sat;
    logic neg_sat;
  } sarcs_result_t;

  localparam int unsigned RESULT_W = $bits(sarcs_result_t);
endpackage : sarcs_pkg

// >>> rtl/sarcs_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sarcs_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d = wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = rp_q + 1'b1;
    end
    case ({push, pop})
      2'b10: cnt_d = cnt_q + 1'b1;
      2'b01: cnt_d = cnt_q - 1'b1;
      default: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

  a_fifo_count: assert property (@(posedge core_clk) disable iff (rst)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule : sarcs_fifo
`default_nettype wire

// >>> rtl/sarcs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - strobe rise in acquisition starts conversion
// - acquisition: grounds closed, inputs connected
// - open grounds first, then arrays to ground
// - two 16-element arrays, one per side
// - MSB-first binary search by comparator decision
// - after search: acquire, code, completion flag
// - conversion timed by core clock only
// - 250 kSPS capable, power down between
// - result belongs to its own strobe
// - 16-bit two's complement output code
// - overrange clamps to 7fff
// - underrange clamps to 8000
// - started conversion ignores strobe
module sarcs_sequencer
  import sarcs_pkg::*;
#(
  parameter int unsigned BITS = RES_BITS,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic convert_strobe,
  input wire logic comp_pos_higher,
  output sarcs_sw_t sw,
  output logic busy,
  output logic powered_up,
  output logic conv_done,
  output logic result_valid,
  input wire logic result_ready,
  output logic [15:0] result_code,
  output logic result_pos_sat,
  output logic result_neg_sat,
  output logic sample_dropped
);
  initial begin
    if (BITS != RES_BITS) $error("array width fixed at sixteen elements");
    if (BITS + SETTLE_CYCLES + 2 > CYCLES_PER_SAMPLE) $error("conversion too slow for rate");
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 4) $error("settle count does not fit its counter");
    if (DEPTH < 2) $error("result buffer needs at least two entries");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic cnv_s1_q, cnv_s2_q, cnv_s3_q;
  logic cmp_s1_q, cmp_s2_q;
  logic cnv_rise;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnv_s1_q <= 1'b0;
      cnv_s2_q <= 1'b0;
      cnv_s3_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cnv_s1_q <= convert_strobe;
      cnv_s2_q <= cnv_s1_q;
      cnv_s3_q <= cnv_s2_q;
      cmp_s1_q <= comp_pos_higher;
      cmp_s2_q <= cmp_s1_q;
    end
  end
  assign cnv_rise = cnv_s2_q && !cnv_s3_q;

  // ----------------------------------------------------------------
  // clamp and code forming
  // ----------------------------------------------------------------
  // the search runs on offset binary; flipping the msb gives two's complement
  function automatic sarcs_result_t form_code(input logic [15:0] trial);
    sarcs_result_t r;
    r.code = {~trial[15], trial[14:0]};
    r.pos_sat = (r.code == CODE_POS_SAT);
    r.neg_sat = (r.code == CODE_NEG_SAT);
    return r;
  endfunction : form_code

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  sarcs_state_t st_q, st_d;
  logic [15:0] trial_q, trial_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] settle_q, settle_d;
  logic done_q, done_d;
  sarcs_result_t res_q, res_d;
  logic push;
  logic fifo_ready;
  logic drop_q, drop_d;

  always_comb begin
    st_d = st_q;
    trial_d = trial_q;
    bit_d = bit_q;
    settle_d = settle_q;
    done_d = 1'b0;
    res_d = res_q;
    drop_d = 1'b0;
    case (st_q)
      SARCS_ACQ: begin
        if (cnv_rise) begin
          st_d = SARCS_OPEN_GND;
          settle_d = 2'(SETTLE_CYCLES - 1);
        end
      end
      SARCS_OPEN_GND: begin
        // hold grounds open before moving the arrays, keeps the held charge intact
        if (settle_q == 2'd0) begin
          st_d = SARCS_TO_GND;
        end else begin
          settle_d = settle_q - 2'd1;
        end
      end
      SARCS_TO_GND: begin
        st_d = SARCS_SEARCH;
        bit_d = 4'(BITS - 1);
        trial_d = 16'h8000;
      end
      SARCS_SEARCH: begin
        // one decision per cycle, internal clock only, strobe ignored
        trial_d[bit_q] = cmp_s2_q;
        if (bit_q == 4'd0) begin
          st_d = SARCS_DONE;
        end else begin
          bit_d = bit_q - 4'd1;
          trial_d[bit_q - 4'd1] = 1'b1;
        end
      end
      SARCS_DONE: begin
        res_d = form_code(trial_q);
        done_d = 1'b1;
        drop_d = !fifo_ready;
        st_d = SARCS_ACQ;
      end
      default: st_d = SARCS_ACQ;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= SARCS_ACQ;
      trial_q <= TRIAL_RESET;
      bit_q <= '0;
      settle_q <= '0;
      done_q <= 1'b0;
      res_q <= '0;
      drop_q <= 1'b0;
    end else begin
      st_q <= st_d;
      trial_q <= trial_d;
      bit_q <= bit_d;
      settle_q <= settle_d;
      done_q <= done_d;
      res_q <= res_d;
      drop_q <= drop_d;
    end
  end

  // ----------------------------------------------------------------
  // switch drive
  // ----------------------------------------------------------------
  always_comb begin
    sw.pos_comparator_ground_switch = (st_q == SARCS_ACQ) || (st_q == SARCS_DONE);
    sw.neg_comparator_ground_switch = sw.pos_comparator_ground_switch;
    sw.inputs_connected = (st_q == SARCS_ACQ) || (st_q == SARCS_OPEN_GND) || (st_q == SARCS_DONE);
    // both arrays get the same trial word mirrored in polarity
    sw.pos_elem_ref = (st_q == SARCS_SEARCH) ? trial_q : '0;
    sw.neg_elem_ref = (st_q == SARCS_SEARCH) ? ~trial_q : '0;
  end

  assign busy = (st_q != SARCS_ACQ);
  // analog core powered only while converting
  assign powered_up = busy;
  assign conv_done = done_q;
  assign sample_dropped = drop_q;
  // a result flagged as dropped is never pushed, even if a pop frees room meanwhile
  assign push = done_q && !drop_q;

  // ----------------------------------------------------------------
  // result buffer; a full buffer loses the newest code, flagged by sample_dropped
  // ----------------------------------------------------------------
  logic [RESULT_W-1:0] fifo_out;
  sarcs_result_t fifo_res;
  sarcs_fifo #(.WIDTH(RESULT_W), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(res_q),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(fifo_out)
  );
  assign fifo_res = sarcs_result_t'(fifo_out);
  assign result_code = fifo_res.code;
  assign result_pos_sat = fifo_res.pos_sat;
  assign result_neg_sat = fifo_res.neg_sat;

  // ----------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------
  // counters read only by the checks; they decode the state on their own so that
  // a fault in the sequencer's own counters cannot hide behind itself
  logic [5:0] pwr_cnt_q, pwr_cnt_d;
  logic [4:0] srch_cnt_q, srch_cnt_d;
  logic [7:0] gap_q, gap_d;
  logic [7:0] starts_q, starts_d;
  logic [7:0] results_q, results_d;
  logic start_taken;

  assign start_taken = (st_q == SARCS_ACQ) && cnv_rise;

  always_comb begin
    pwr_cnt_d = 6'h00;
    srch_cnt_d = 5'h00;
    gap_d = gap_q;
    starts_d = starts_q;
    results_d = results_q;
    if (powered_up) begin
      pwr_cnt_d = (pwr_cnt_q == 6'h3f) ? pwr_cnt_q : pwr_cnt_q + 6'h01;
    end
    if (st_q == SARCS_SEARCH) begin
      srch_cnt_d = (srch_cnt_q == 5'h1f) ? srch_cnt_q : srch_cnt_q + 5'h01;
    end
    // spacing saturates, so an idle stretch of any length reads as long enough
    if (start_taken) begin
      gap_d = 8'h00;
      starts_d = starts_q + 8'h01;
    end else if (gap_q != 8'hff) begin
      gap_d = gap_q + 8'h01;
    end
    if (conv_done) begin
      results_d = results_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_cnt_q <= 6'h00;
      srch_cnt_q <= 5'h00;
      gap_q <= 8'hff;
      starts_q <= 8'h00;
      results_q <= 8'h00;
    end else begin
      pwr_cnt_q <= pwr_cnt_d;
      srch_cnt_q <= srch_cnt_d;
      gap_q <= gap_d;
      starts_q <= starts_d;
      results_q <= results_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // start of a conversion and the switch order
  a_start_conv: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == SARCS_ACQ && cnv_rise) |=> st_q == SARCS_OPEN_GND)
    else $error("strobe did not start");
  a_acq_switches: assert property (@(posedge core_clk) disable iff (rst)
    st_q == SARCS_ACQ |-> sw.pos_comparator_ground_switch && sw.neg_comparator_ground_switch
      && sw.inputs_connected) else $error("acq switches");
  a_acq_elems_idle: assert property (@(posedge core_clk) disable iff (rst)
    st_q == SARCS_ACQ |-> (sw.pos_elem_ref | sw.neg_elem_ref) == 16'h0000)
    else $error("elements not idle");
  a_ground_first: assert property (@(posedge core_clk) disable iff (rst)
    $rose(busy) |-> !sw.pos_comparator_ground_switch && sw.inputs_connected)
    else $error("order wrong");
  a_open_before_move: assert property (@(posedge core_clk) disable iff (rst)
    $fell(sw.inputs_connected) |-> !$past(sw.pos_comparator_ground_switch)
      && !$past(sw.neg_comparator_ground_switch)) else $error("arrays moved before grounds opened");
  a_arrays_grounded: assert property (@(posedge core_clk) disable iff (rst)
    st_q inside {SARCS_TO_GND, SARCS_SEARCH} |-> !sw.inputs_connected
      && !sw.pos_comparator_ground_switch && !sw.neg_comparator_ground_switch) else $error("arrays not on ground");

  // binary search
  a_neg_mirror: assert property (@(posedge core_clk) disable iff (rst)
    st_q == SARCS_SEARCH |-> sw.neg_elem_ref == ~sw.pos_elem_ref)
    else $error("arrays differ");
  a_msb_first: assert property (@(posedge core_clk) disable iff (rst)
    st_q == SARCS_TO_GND |=> trial_q == 16'h8000 && bit_q == 4'd15)
    else $error("search start");
  a_trial_probe: assert property (@(posedge core_clk) disable iff (rst)
    st_q == SARCS_SEARCH |-> trial_q[bit_q] && ((trial_q & ((16'h0001 << bit_q) - 16'h0001)) == 16'h0000))
    else $error("trial bit not probed");
  a_bit_kept: assert property (@(posedge core_clk) disable iff (rst)
    st_q == SARCS_SEARCH |=> trial_q[$past(bit_q)] == $past(cmp_s2_q))
    else $error("decision not kept");
  a_conv_len: assert property (@(posedge core_clk) disable iff (rst)
    $rose(busy) |-> busy [*8] ##1 busy [*8] ##1 busy [*4] ##1 (conv_done && !busy))
    else $error("conversion length");
  a_search_len: assert property (@(posedge core_clk) disable iff (rst)
    st_q == SARCS_SEARCH |-> srch_cnt_q < 5'(BITS))
    else $error("search too long");
  a_search_count: assert property (@(posedge core_clk) disable iff (rst)
    st_q == SARCS_DONE |-> srch_cnt_q == 5'(BITS))
    else $error("wrong number of decisions");

  // power and rate
  a_done_idle: assert property (@(posedge core_clk) disable iff (rst)
    conv_done |-> st_q == SARCS_ACQ && !powered_up)
    else $error("not idle after");
  a_power_window: assert property (@(posedge core_clk) disable iff (rst)
    powered_up |-> pwr_cnt_q < 6'(CONV_CYCLES))
    else $error("powered too long");
  a_power_count: assert property (@(posedge core_clk) disable iff (rst)
    conv_done |-> pwr_cnt_q == 6'(CONV_CYCLES))
    else $error("powered cycles per conversion");
  a_start_spacing: assert property (@(posedge core_clk) disable iff (rst)
    start_taken |-> gap_q >= 8'(CONV_CYCLES))
    else $error("start inside running conversion");
  a_no_restart: assert property (@(posedge core_clk) disable iff (rst)
    st_q == SARCS_SEARCH |=> st_q inside {SARCS_SEARCH, SARCS_DONE})
    else $error("aborted");
  a_strobe_ignored: assert property (@(posedge core_clk) disable iff (rst)
    st_q inside {SARCS_TO_GND, SARCS_SEARCH, SARCS_DONE} && cnv_rise |=> st_q != SARCS_OPEN_GND)
    else $error("strobe restarted conversion");

  // result forming
  a_code_map: assert property (@(posedge core_clk) disable iff (rst)
    st_q == SARCS_DONE |=> res_q.code == {~$past(trial_q[15]), $past(trial_q[14:0])})
    else $error("code");
  a_sat_flags: assert property (@(posedge core_clk) disable iff (rst)
    conv_done |-> res_q.pos_sat == (res_q.code == 16'h7fff) && res_q.neg_sat == (res_q.code == 16'h8000))
    else $error("sat flags");
  a_one_in_flight: assert property (@(posedge core_clk) disable iff (rst)
    8'(starts_q - results_q) <= 8'd1)
    else $error("more than one sample in flight");
  a_result_count: assert property (@(posedge core_clk) disable iff (rst)
    conv_done |-> 8'(starts_q - results_q) == 8'd1)
    else $error("result without its start");
  a_drop_with_done: assert property (@(posedge core_clk) disable iff (rst)
    sample_dropped |-> conv_done)
    else $error("drop outside completion");

  c_conv: cover property (@(posedge core_clk) disable iff (rst) conv_done);
  c_pos_sat: cover property (@(posedge core_clk) disable iff (rst) conv_done && res_q.pos_sat);
  c_neg_sat: cover property (@(posedge core_clk) disable iff (rst) conv_done && res_q.neg_sat);
  c_drop: cover property (@(posedge core_clk) disable iff (rst) sample_dropped);
  c_strobe_ignored: cover property (@(posedge core_clk) disable iff (rst) busy && cnv_rise);
endmodule : sarcs_sequencer
`default_nettype wire

// >>> tb/sarcs_comp_model.sv
`timescale 1ns/1ps
`default_nettype none
module sarcs_comp_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic busy,
  input wire logic [15:0] level,
  output logic comp_pos_higher
);
  // ----------------------------------------------------------------
  // comparator seen from the switch array
  // ----------------------------------------------------------------
  logic [4:0] cnt_q;
  logic wig_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'h00;
      wig_q <= 1'b0;
    end else begin
      cnt_q <= busy ? ((cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01) : 5'h00;
      wig_q <= ~wig_q;
    end
  end

  // leads the search by the two synchroniser stages, so each bit decision
  // equals the held level's bit; outside the search the line wiggles
  always_comb begin
    if (busy && cnt_q >= 5'h01 && cnt_q <= 5'h10) begin
      comp_pos_higher = level[4'(5'h10 - cnt_q)];
    end else begin
      comp_pos_higher = wig_q;
    end
  end
endmodule : sarcs_comp_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sarcs_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic convert_strobe = 1'b0;
  logic result_ready = 1'b0;
  logic [1:0] rdy_mode = 2'h0;
  logic [15:0] level = 16'h0000;
  logic comp_pos_higher;
  sarcs_sw_t sw;
  logic busy, powered_up, conv_done, result_valid, result_pos_sat, result_neg_sat, sample_dropped;
  logic [15:0] result_code;
  sarcs_result_t exp_q[$];
  sarcs_result_t mon_e;
  int mismatches = 0;
  int n_compared = 0;
  logic [15:0] codes [6] = '{16'h8000, 16'h8001, 16'h7fff, 16'hffff, 16'h0000, 16'h0001};

  sarcs_sequencer u_sarcs_sequencer (.core_clk(core_clk), .rst(rst), .convert_strobe(convert_strobe),
    .comp_pos_higher(comp_pos_higher), .sw(sw), .busy(busy), .powered_up(powered_up), .conv_done(conv_done),
    .result_valid(result_valid), .result_ready(result_ready), .result_code(result_code),
    .result_pos_sat(result_pos_sat), .result_neg_sat(result_neg_sat), .sample_dropped(sample_dropped));
  sarcs_comp_model u_comp_model (.core_clk(core_clk), .rst(rst), .busy(busy), .level(level),
    .comp_pos_higher(comp_pos_higher));

  always #12.5 core_clk = ~core_clk;
  // mode 2 stalls the reader at random to keep results queued
  always @(negedge core_clk) result_ready <= (rdy_mode == 2'h2) ? 1'($urandom_range(1, 0)) : rdy_mode[0];

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic give_up(input string msg);
    mismatches++;
    $display("[FAIL] %0t timeout %s", $time, msg);
    print_verdict();
  endtask : give_up

  always @(posedge core_clk) begin
    if (!rst && result_valid === 1'b1 && result_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(16'h0001, 16'h0000, "unexpected result");
      end else begin
        mon_e = exp_q.pop_front();
        chk(result_code, mon_e.code, "result code");
        chk(result_pos_sat, mon_e.pos_sat, "positive clamp flag");
        chk(result_neg_sat, mon_e.neg_sat, "negative clamp flag");
      end
    end
  end

  // ----------------------------------------------------------------
  // one conversion with a strobe glitch in mid-conversion
  // ----------------------------------------------------------------
  task automatic convert(input logic [15:0] tgt, input logic drop);
    int n;
    sarcs_result_t e;
    level = tgt;
    convert_strobe = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (busy !== 1'b1) give_up("busy");
    chk(sw.pos_comparator_ground_switch, 16'h0000, "grounds open at start");
    chk(sw.neg_comparator_ground_switch, 16'h0000, "grounds open at start");
    n = 0;
    while (conv_done !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
      if (n == 2) chk(sw.inputs_connected, 16'h0000, "arrays off inputs");
      if (n == 4) chk(sw.pos_elem_ref, {tgt[15], 1'b1, 14'h0000}, "first decision");
      if (n == 4) chk(sw.neg_elem_ref, ~{tgt[15], 1'b1, 14'h0000}, "mirrored array");
      if (n == 5) convert_strobe = 1'b0;
      if (n == 8) convert_strobe = 1'b1;
    end
    if (conv_done !== 1'b1) give_up("done");
    chk(16'(n), 16'd20, "done latency");
    chk(sample_dropped, drop, "drop pulse");
    chk(busy, 16'h0000, "busy after done");
    chk(powered_up, 16'h0000, "powered after done");
    chk({sw.pos_comparator_ground_switch, sw.neg_comparator_ground_switch, sw.inputs_connected},
      16'h0007, "acquire switches");
    chk(sw.pos_elem_ref | sw.neg_elem_ref, 16'h0000, "elements idle");
    e.code = tgt ^ 16'h8000;
    e.pos_sat = (e.code == CODE_POS_SAT);
    e.neg_sat = (e.code == CODE_NEG_SAT);
    if (!drop) exp_q.push_back(e);
    convert_strobe = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(busy, 16'h0000, "no restart from glitch");
  endtask : convert

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    if (exp_q.size() != 0) give_up("drain");
    repeat (2) @(negedge core_clk);
    chk(result_valid, 16'h0000, "fifo empty");
  endtask : drain

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h3d2d));
    repeat (4) @(negedge core_clk);
    chk({busy, result_valid, sw.inputs_connected}, 16'h0001, "reset outputs");
    rst = 1'b0;
    @(negedge core_clk);
    rdy_mode = 2'h1;
    foreach (codes[i]) convert(codes[i], 1'b0);
    drain();
    $display("test codes done");
    rdy_mode = 2'h2;
    repeat (8) convert(16'($urandom), 1'b0);
    drain();
    $display("test random done");
    rdy_mode = 2'h0;
    for (int i = 0; i < 17; i++) convert(16'($urandom), 1'(i == 16));
    rdy_mode = 2'h2;
    drain();
    $display("test fill done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
